// ### include/tcm_defs.vh
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

// ********************************
// register byte offsets
// ********************************
`define TCM_OFF_CTRL 8'h00
`define TCM_OFF_VALUE 8'h04
`define TCM_OFF_MODCTRL 8'h08
`define TCM_OFF_STAT 8'h0C
`define TCM_OFF_MASK 8'h10

// ********************************
// channel control, mode control and status field positions
// ********************************
`define TCM_CTRL_FLAG 7
`define TCM_CTRL_IE 6
`define TCM_CTRL_MSHI 5
`define TCM_CTRL_MSLO 4
`define TCM_CTRL_ELHI 3
`define TCM_CTRL_ELLO 2
`define TCM_MOD_CENTER 0
`define TCM_STAT_EVENT 0
`define TCM_STAT_OVER 1

// ********************************
// reset values
// ********************************
`define TCM_RST_CTRL 8'h00
`define TCM_RST_VALUE 16'h0000
`define TCM_RST_STAT 2'h0
`define TCM_RST_MASK 2'h0

// ********************************
// channel modes and edge/level codes
// ********************************
`define TCM_MODE_IC 2'h0
`define TCM_MODE_OC 2'h1
`define TCM_MODE_EPWM 2'h2
`define TCM_MODE_CPWM 2'h3
`define TCM_EL_OFF 2'h0
`define TCM_EL_01 2'h1
`define TCM_EL_10 2'h2
`define TCM_EL_11 2'h3

// ********************************
// timing counts
// ********************************
`define TCM_IC_SETTLE 2'h2

`endif

// ### logic/tcm_channel.v
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "tcm_defs.vh"
module tcm_channel (
	input wire clock, // bus clock, 50 MHz
	input wire resetn, // synchronous reset, active low
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction, high for write
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata_r, // apb read data
	output reg pready_r, // apb ready
	output reg pslverr_r, // apb error on unmapped address
	input wire [15:0] counterValue, // shared counter value
	input wire counterTick, // counter changed this cycle
	input wire countingUp, // counter direction, high when up
	input wire [15:0] modValue, // counter modulo, 0 is free run
	input wire pinIn, // channel pin level
	output reg pinOut_r, // channel pin drive level
	output reg pinOe_r, // channel pin output enable
	output reg centerMode_r, // counter to up/down counting
	output reg chanIrq_r, // channel interrupt request
	output reg irq_r // masked status interrupt
);

// ********************************
// functions
// ********************************
function regHit;
	input [7:0] addr;
	input [7:0] off;
	begin
		regHit = (addr == off);
	end
endfunction

function [1:0] chanMode;
	input center;
	input msHi;
	input msLo;
	begin
		if (center)
			chanMode = `TCM_MODE_CPWM;
		else if (msHi)
			chanMode = `TCM_MODE_EPWM;
		else if (msLo)
			chanMode = `TCM_MODE_OC;
		else
			chanMode = `TCM_MODE_IC;
	end
endfunction

// ********************************
// registers
// ********************************
reg flag_r;
reg ie_r;
reg msHi_r;
reg msLo_r;
reg [1:0] el_r;
reg [15:0] value_r;
reg centerSel_r;
reg [1:0] stat_r;
reg [1:0] mask_r;
reg clrArmed_r;
reg [1:0] settle_r;
reg wasCap_r;

reg flag_nxt;
reg clrArmed_nxt;
reg [1:0] stat_nxt;
reg pinOut_nxt;
reg [31:0] rdData;
reg hitAny;

wire rise;
wire fall;

tcm_edge_sync uSync (
	.clock(clock),
	.resetn(resetn),
	.pinIn(pinIn),
	.rise_r(rise),
	.fall_r(fall)
);

// ********************************
// bus decode
// ********************************
wire access = psel & penable & pready_r;
wire wrDone = access & pwrite;
wire rdDone = access & ~pwrite;
wire hitCtrl = regHit(paddr, `TCM_OFF_CTRL);
wire hitValue = regHit(paddr, `TCM_OFF_VALUE);
wire hitMod = regHit(paddr, `TCM_OFF_MODCTRL);
wire hitStat = regHit(paddr, `TCM_OFF_STAT);
wire hitMask = regHit(paddr, `TCM_OFF_MASK);

// ********************************
// mode and event decode
// ********************************
wire [1:0] mode = chanMode(centerSel_r, msHi_r, msLo_r);
wire isCap = (mode == `TCM_MODE_IC);
wire isPwm = (mode == `TCM_MODE_EPWM) | (mode == `TCM_MODE_CPWM);
wire pinUsed = (el_r != `TCM_EL_OFF);
wire settled = (settle_r == 2'h0);
// high-true level at period start; X1 codes are low-true
wire activeLvl = (el_r == `TCM_EL_10);

reg edgeSeen;
always @* begin
	case (el_r)
		`TCM_EL_01: edgeSeen = rise;
		`TCM_EL_10: edgeSeen = fall;
		`TCM_EL_11: edgeSeen = rise | fall;
		default: edgeSeen = 1'b0;
	endcase
end

// the edge register lags the pin, so the first capture cycle is
// guarded as well as the two counted ones
wire capReady = settled & wasCap_r;
wire capEvent = isCap & capReady & edgeSeen;
wire match = counterTick & (counterValue == value_r);
// duty of 0% is value 0; 100% is value beyond modulo
wire dutyZero = (value_r == 16'h0000);
wire dutyFull = (modValue != 16'h0000) & (value_r > modValue);
wire dutyEdge = isPwm & (dutyZero | dutyFull);
wire cmpEvent = ~isCap & match & ~dutyEdge;
wire chanEvent = capEvent | cmpEvent;

// arm on the word the reader actually got, so an event landing after
// the read data was sampled is never cleared by a blind write
wire sawFlag = prdata_r[`TCM_CTRL_FLAG];

// ********************************
// flag clearing sequence
// ********************************
always @* begin
	flag_nxt = flag_r;
	clrArmed_nxt = clrArmed_r;
	if (chanEvent) begin
		// a fresh event restarts the sequence so it is never lost
		flag_nxt = 1'b1;
		clrArmed_nxt = 1'b0;
	end else if (wrDone & hitCtrl) begin
		// writing 1 leaves the flag alone
		if (clrArmed_r & ~pwdata[`TCM_CTRL_FLAG])
			flag_nxt = 1'b0;
		clrArmed_nxt = 1'b0;
	end else if (rdDone & hitCtrl & sawFlag) begin
		clrArmed_nxt = 1'b1;
	end
end

// ********************************
// status bits, set wins over clear
// ********************************
always @* begin
	stat_nxt = stat_r;
	if (wrDone & hitStat)
		stat_nxt = stat_r & ~pwdata[1:0];
	if (chanEvent)
		stat_nxt[`TCM_STAT_EVENT] = 1'b1;
	// overrun marks an event that arrives while the flag is still up
	if (chanEvent & flag_r)
		stat_nxt[`TCM_STAT_OVER] = 1'b1;
end

// ********************************
// pin drive level
// ********************************
always @* begin
	pinOut_nxt = pinOut_r;
	case (mode)
		`TCM_MODE_OC: begin
			if (match) begin
				case (el_r)
					`TCM_EL_01: pinOut_nxt = ~pinOut_r;
					`TCM_EL_10: pinOut_nxt = 1'b0;
					`TCM_EL_11: pinOut_nxt = 1'b1;
					default: pinOut_nxt = pinOut_r;
				endcase
			end
		end
		`TCM_MODE_EPWM: begin
			// 0% and 100% pin the level for the whole period
			if (dutyZero)
				pinOut_nxt = ~activeLvl;
			else if (dutyFull)
				pinOut_nxt = activeLvl;
			else if (match)
				pinOut_nxt = ~activeLvl;
			else if (counterTick & (counterValue == 16'h0000))
				pinOut_nxt = activeLvl;
		end
		`TCM_MODE_CPWM: begin
			if (dutyZero)
				pinOut_nxt = ~activeLvl;
			else if (dutyFull)
				pinOut_nxt = activeLvl;
			else if (match & countingUp)
				pinOut_nxt = ~activeLvl;
			else if (match)
				pinOut_nxt = activeLvl;
		end
		default: pinOut_nxt = pinOut_r;
	endcase
end

// ********************************
// read data mux
// ********************************
always @* begin
	rdData = 32'h00000000;
	hitAny = 1'b1;
	if (hitCtrl)
		rdData[7:0] = {flag_r, ie_r, msHi_r, msLo_r, el_r, 2'h0};
	else if (hitValue)
		rdData[15:0] = value_r;
	else if (hitMod)
		rdData[`TCM_MOD_CENTER] = centerSel_r;
	else if (hitStat)
		rdData[1:0] = stat_r;
	else if (hitMask)
		rdData[1:0] = mask_r;
	else
		hitAny = 1'b0;
end

// ********************************
// apb handshake, one wait state
// ********************************
always @(posedge clock) begin
	if (!resetn) begin
		pready_r <= 1'b0;
		pslverr_r <= 1'b0;
		prdata_r <= 32'h00000000;
	end else begin
		pready_r <= psel & penable & ~pready_r;
		pslverr_r <= psel & penable & ~pready_r & ~hitAny;
		// writes answer zero, so a refused write never shows stale data
		if (psel & penable & ~pready_r)
			prdata_r <= pwrite ? 32'h00000000 : rdData;
	end
end

// ********************************
// control and value registers
// ********************************
always @(posedge clock) begin
	if (!resetn) begin
		flag_r <= 1'b0;
		ie_r <= 1'b0;
		msHi_r <= 1'b0;
		msLo_r <= 1'b0;
		el_r <= `TCM_EL_OFF;
		value_r <= `TCM_RST_VALUE;
		centerSel_r <= 1'b0;
		clrArmed_r <= 1'b0;
	end else begin
		flag_r <= flag_nxt;
		clrArmed_r <= clrArmed_nxt;
		if (wrDone & hitCtrl) begin
			ie_r <= pwdata[`TCM_CTRL_IE];
			msHi_r <= pwdata[`TCM_CTRL_MSHI];
			msLo_r <= pwdata[`TCM_CTRL_MSLO];
			el_r <= pwdata[`TCM_CTRL_ELHI:`TCM_CTRL_ELLO];
		end
		if (wrDone & hitMod)
			centerSel_r <= pwdata[`TCM_MOD_CENTER];
		// capture owns the value register; bus writes ignored then
		if (capEvent)
			value_r <= counterValue;
		else if (wrDone & hitValue & ~isCap)
			value_r <= pwdata[15:0];
	end
end

// ********************************
// capture entry settling
// ********************************
// stale samples from before capture could look like an edge
always @(posedge clock) begin
	if (!resetn) begin
		settle_r <= `TCM_IC_SETTLE;
		wasCap_r <= 1'b0;
	end else begin
		wasCap_r <= isCap;
		if (isCap & ~wasCap_r)
			settle_r <= `TCM_IC_SETTLE;
		else if (!settled)
			settle_r <= settle_r - 2'h1;
	end
end

// ********************************
// interrupts and pin outputs
// ********************************
always @(posedge clock) begin
	if (!resetn) begin
		stat_r <= `TCM_RST_STAT;
		mask_r <= `TCM_RST_MASK;
		irq_r <= 1'b0;
		chanIrq_r <= 1'b0;
		pinOut_r <= 1'b0;
		pinOe_r <= 1'b0;
		centerMode_r <= 1'b0;
	end else begin
		stat_r <= stat_nxt;
		if (wrDone & hitMask)
			mask_r <= pwdata[1:0];
		// both requests lag their sources by one cycle, all registered
		irq_r <= |(stat_r & mask_r);
		chanIrq_r <= flag_r & ie_r;
		pinOut_r <= pinOut_nxt;
		// capture only reads the pin, 00 hands it back
		pinOe_r <= pinUsed & ~isCap;
		centerMode_r <= centerSel_r;
	end
end

endmodule // tcm_channel

// ### logic/tcm_edge_sync.v
`timescale 1ns/1ns
module tcm_edge_sync (
	input wire clock, // bus clock
	input wire resetn, // synchronous reset, active low
	input wire pinIn, // raw channel pin level
	output reg rise_r, // one-cycle pulse on rising edge
	output reg fall_r // one-cycle pulse on falling edge
);

reg meta_r;
reg sync_r;
reg prev_r;

// first stage feeds only the second stage
always @(posedge clock) begin
	if (!resetn) begin
		meta_r <= 1'b0;
		sync_r <= 1'b0;
		prev_r <= 1'b0;
		rise_r <= 1'b0;
		fall_r <= 1'b0;
	end else begin
		meta_r <= pinIn;
		sync_r <= meta_r;
		prev_r <= sync_r;
		rise_r <= sync_r & ~prev_r;
		fall_r <= ~sync_r & prev_r;
	end
end

endmodule // tcm_edge_sync

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
	reg clock, resetn, psel, penable, pwrite, counterTick, pinLvl;
	reg [7:0] paddr;
	reg [31:0] pwdata, q;
	reg [15:0] counterValue, modValue;
	reg e, countingUp;
	wire [31:0] prdata_r;
	wire pready_r, pslverr_r, pinOut_r, pinOe_r, centerMode_r;
	wire chanIrq_r, irq_r, pinLevel;
	integer miscompares, checks_done, i;
	always #10 clock = ~clock;
	tcm_channel tcm_channel_inst (.clock(clock), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
		.pslverr_r(pslverr_r), .counterValue(counterValue),
		.counterTick(counterTick), .countingUp(countingUp),
		.modValue(modValue), .pinIn(pinLevel), .pinOut_r(pinOut_r),
		.pinOe_r(pinOe_r), .centerMode_r(centerMode_r),
		.chanIrq_r(chanIrq_r), .irq_r(irq_r));
	tcm_pin_model tcm_pin_model_inst (.pinOut_r(pinOut_r),
		.pinOe_r(pinOe_r), .extEn(1'h1), .extLvl(pinLvl),
		.pinLevel(pinLevel));
	// ********************************
	// bus, counter and check tasks
	// ********************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		begin
			@(posedge clock);
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'h1;
			n = 0;
			@(posedge clock);
			while (pready_r !== 1'h1 && n < 20) begin
				@(posedge clock);
				n = n + 1;
			end
			chk(n < 20, 1'h1);
			q = prdata_r;
			e = pslverr_r;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		begin
			apb(1'h0, a, 32'h0);
			chk(q, exp);
		end
	endtask
	task hit;
		begin
			@(posedge clock);
			counterValue <= 16'h0010;
			counterTick <= 1'h1;
			@(posedge clock);
			counterTick <= 1'h0;
			counterValue <= 16'h0011;
			repeat (3) @(posedge clock);
		end
	endtask
	task tick(input logic [15:0] v);
		begin
			@(posedge clock);
			counterValue <= v;
			counterTick <= 1'h1;
			@(posedge clock);
			counterTick <= 1'h0;
			repeat (2) @(posedge clock);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d bad %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		#100000;
		$display("BAD %0t watchdog", $time);
		miscompares = miscompares + 1;
		conclude;
	end
	initial begin
		{clock, resetn, psel, penable, pwrite, counterTick, pinLvl} = 7'h0;
		{paddr, pwdata, counterValue} = 56'h0;
		countingUp = 1'h1;
		modValue = 16'h0000;
		miscompares = 0;
		checks_done = 0;
		repeat (12) @(posedge clock);
		resetn <= 1'h1;
		rd(8'h00, 32'h0);
		rd(8'h14, 32'h0);
		chk(e, 1'h1);
		$display("test reset done");
		for (i = 0; i < 3; i = i + 1) begin
			apb(1'h1, 8'h00, 32'h50 | ((32'h3 - i) << 2));
			if (i == 0)
				apb(1'h1, 8'h04, 32'h10);
			hit;
			chk(pinOut_r, i != 1);
			chk(pinOe_r, 1'h1);
		end
		chk(chanIrq_r, 1'h1);
		rd(8'h0C, 32'h3);
		apb(1'h1, 8'h10, 32'h1);
		repeat (2) @(posedge clock);
		chk(irq_r, 1'h1);
		apb(1'h1, 8'h10, 32'h0);
		repeat (2) @(posedge clock);
		chk(irq_r, 1'h0);
		apb(1'h1, 8'h10, 32'h1);
		apb(1'h1, 8'h0C, 32'h3);
		repeat (2) @(posedge clock);
		chk(irq_r, 1'h0);
		rd(8'h0C, 32'h0);
		$display("test compare done");
		rd(8'h00, 32'hD4);
		apb(1'h1, 8'h00, 32'hD4);
		rd(8'h00, 32'hD4);
		apb(1'h1, 8'h00, 32'h54);
		rd(8'h00, 32'h54);
		repeat (2) @(posedge clock);
		chk(chanIrq_r, 1'h0);
		hit;
		rd(8'h00, 32'hD4);
		hit;
		apb(1'h1, 8'h00, 32'h54);
		rd(8'h00, 32'hD4);
		apb(1'h1, 8'h00, 32'h10);
		hit;
		rd(8'h00, 32'h90);
		chk(pinOe_r, 1'h0);
		$display("test clear done");
		apb(1'h1, 8'h00, 32'h04);
		repeat (4) @(posedge clock);
		chk(pinOe_r, 1'h0);
		pinLvl <= 1'h1;
		repeat (8) @(posedge clock);
		rd(8'h00, 32'h84);
		rd(8'h04, 32'h11);
		apb(1'h1, 8'h04, 32'h55);
		rd(8'h04, 32'h11);
		apb(1'h1, 8'h00, 32'h04);
		pinLvl <= 1'h0;
		repeat (8) @(posedge clock);
		rd(8'h00, 32'h04);
		apb(1'h1, 8'h00, 32'h0C);
		pinLvl <= 1'h1;
		repeat (8) @(posedge clock);
		rd(8'h00, 32'h8C);
		$display("test capture done");
		apb(1'h1, 8'h00, 32'h28);
		apb(1'h1, 8'h04, 32'h20);
		tick(16'h0000);
		chk(pinOut_r, 1'h1);
		tick(16'h0020);
		chk(pinOut_r, 1'h0);
		rd(8'h00, 32'hA8);
		apb(1'h1, 8'h00, 32'h28);
		apb(1'h1, 8'h04, 32'h0);
		tick(16'h0000);
		chk(pinOut_r, 1'h0);
		rd(8'h00, 32'h28);
		modValue <= 16'h0030;
		apb(1'h1, 8'h04, 32'h40);
		tick(16'h0040);
		chk(pinOut_r, 1'h1);
		rd(8'h00, 32'h28);
		apb(1'h1, 8'h00, 32'h24);
		apb(1'h1, 8'h04, 32'h20);
		tick(16'h0000);
		chk(pinOut_r, 1'h0);
		tick(16'h0020);
		chk(pinOut_r, 1'h1);
		$display("test pwm done");
		apb(1'h1, 8'h08, 32'h1);
		repeat (2) @(posedge clock);
		chk(centerMode_r, 1'h1);
		apb(1'h1, 8'h00, 32'h08);
		tick(16'h0020);
		chk(pinOut_r, 1'h0);
		countingUp <= 1'h0;
		tick(16'h0020);
		chk(pinOut_r, 1'h1);
		chk(pinOe_r, 1'h1);
		$display("test center done");
		conclude;
	end
endmodule // tb

// ### tb/tcm_channel_sva.sv
`timescale 1ns/1ns
module tcm_channel_sva (
	input wire clock, // clock
	input wire resetn, // reset
	input wire psel, // select
	input wire penable, // enable
	input wire pwrite, // write
	input wire [7:0] paddr, // address
	input wire [31:0] pwdata, // wdata
	input wire [31:0] prdata_r, // rdata
	input wire pready_r, // ready
	input wire pslverr_r, // error
	input wire pinOe_r, // pin enable
	input wire centerMode_r, // center
	input wire chanIrq_r // request
);
	reg [7:0] ctrlS_r;
	reg cenS_r;
	wire wrDone = psel && penable && pready_r && pwrite;
	wire mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
	always @(posedge clock) begin
		if (!resetn) begin
			ctrlS_r <= 8'h00;
			cenS_r <= 1'h0;
		end else if (wrDone && paddr == 8'h00) begin
			ctrlS_r <= pwdata[7:0];
		end else if (wrDone && paddr == 8'h08) begin
			cenS_r <= pwdata[0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_READY_ONE: assert property (pready_r |=> !pready_r)
		else $error("ready held");
	AST_READY_LAT: assert property ($rose(penable) && psel |=> pready_r)
		else $error("ready late");
	AST_IDLE: assert property (!psel |=> !pready_r)
		else $error("ready while idle");
	AST_ERR_MAP: assert property (pready_r |-> pslverr_r == !mapped)
		else $error("error flag wrong");
	AST_ERR_DATA: assert property (pslverr_r |-> prdata_r == 32'h0)
		else $error("error data");
	AST_READ_HI: assert property (pready_r |-> prdata_r[31:16] == 16'h0)
		else $error("upper bits");
	AST_PIN_FREE: assert property (ctrlS_r[3:2] == 2'h0 &&
		$past(ctrlS_r[3:2]) == 2'h0 |-> !pinOe_r) else $error("pin held");
	AST_CENTER: assert property (cenS_r == $past(cenS_r)
		|-> centerMode_r == cenS_r) else $error("center copy");
	AST_IRQ_OFF: assert property (!ctrlS_r[6] && !$past(ctrlS_r[6])
		|-> !chanIrq_r) else $error("request masked");
endmodule // tcm_channel_sva
bind tcm_channel tcm_channel_sva tcm_channel_sva_inst (.clock(clock),
	.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
	.pready_r(pready_r), .pslverr_r(pslverr_r), .pinOe_r(pinOe_r),
	.centerMode_r(centerMode_r), .chanIrq_r(chanIrq_r));

// ### tb/tcm_pin_model.sv
`timescale 1ns/1ns
module tcm_pin_model (
	input wire pinOut_r, // drive level
	input wire pinOe_r, // drive enable
	input wire extEn, // far side drives
	input wire extLvl, // far side level
	output wire pinLevel // wire level
);
	// a pull-up holds a released pin high
	assign pinLevel = pinOe_r ? pinOut_r : (extEn ? extLvl : 1'h1);
endmodule // tcm_pin_model
